// ==== hw/sac_adc_ctrl.sv ====
// Purpose: control, sequencing and result registers of a 10-bit SAR converter
// Assumes: APB slave on pclk; comparator input is synchronous to pclk
// Notes:   analog mux, DAC and comparator live outside; no interrupt output
//
// What this block does
// - high register D9..D2, low register D1..D0
// - input above reference gives full scale, no flag
// - four-bit channel field selects input 0..15
// - setting on bit starts continuous conversions
// - clearing on bit stops conversion at once
// - completion sets read-only end flag, updates results
// - high read or control write clears flag
// - every completion overwrites both result registers, except one aborted by a channel change in the done cycle
// - channel change aborts, clears flag, restarts
// - speed bit picks pclk/4 or pclk/2
// - wait mode leaves converter running
// - halt disables; settle time after wakeup
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module sac_adc_ctrl
  import sac_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // power modes
  input  wire logic        wait_mode,
  input  wire logic        halt_mode,
  // analog front end
  input  wire logic        cmp_above,
  output sac_ana_s         ana
);

  // ------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------
  sac_state_s st_ff;
  sac_state_s nxt_st;

  logic       tick;
  logic       setup;
  logic       access;
  logic       addr_ok;
  logic [7:0] rd_mux;
  logic [7:0] csr_view;
  logic       wr_csr;
  logic       rd_rh;
  logic       run;
  logic       busy;
  logic       restart;
  logic       ch_change;
  logic       done_evt;

  assign setup    = psel & ~penable;
  assign access   = psel & penable & st_ff.pready;
  // reserved bit 4 always reads zero
  assign csr_view = {st_ff.eoc, st_ff.speed, st_ff.on, 1'b0, st_ff.ch};
  // wait mode intentionally not used: it changes nothing here
  assign run      = st_ff.on & ~halt_mode;
  assign busy     = (st_ff.state == ST_SAMPLE) || (st_ff.state == ST_CONV);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  always_comb
  begin
    rd_mux  = 8'h00;
    addr_ok = 1'b1;
    if (paddr == ADDR_CSR)
    begin
      rd_mux = csr_view;
    end
    else if (paddr == ADDR_RH)
    begin
      rd_mux = st_ff.res[RES_W-1:2];
    end
    else if (paddr == ADDR_RL)
    begin
      rd_mux = {6'h00, st_ff.res[1:0]};
    end
    else
    begin
      addr_ok = 1'b0;
    end
  end

  // a write with the low strobe clear changes nothing, the flag included
  assign wr_csr    = access & pwrite & ~st_ff.pslverr & (paddr == ADDR_CSR) & pstrb[0];
  assign rd_rh     = access & ~pwrite & (paddr == ADDR_RH);
  assign ch_change = wr_csr && (pwdata[CH_LSB +: CH_W] != st_ff.ch);
  // a completion counts only while the converter is still on and awake
  assign done_evt  = (st_ff.state == ST_DONE) && run;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    restart        = 1'b0;

    // ------------------------------------------------------------
    // apb: answer is prepared in setup and stands in the access cycle
    // ------------------------------------------------------------
    // read data is taken in setup, so a completion cannot tear it
    if (setup)
    begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = ~addr_ok;
      nxt_st.prdata  = pwrite ? 8'h00 : rd_mux;
    end
    else if (access)
    begin
      nxt_st.prdata = 8'h00;
    end

    // ------------------------------------------------------------
    // halt: converter off, settle time owed at wakeup
    // ------------------------------------------------------------
    // the settle wait is owed after every halt, even with the converter off
    if (halt_mode)
    begin
      nxt_st.settle_pend = 1'b1;
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    case (st_ff.state)
      ST_IDLE:
      begin
        if (!halt_mode && st_ff.settle_pend)
        begin
          nxt_st.state = ST_SETTLE;
          nxt_st.cnt   = SETTLE_CYC;
        end
        else if (run)
        begin
          nxt_st.state = ST_SAMPLE;
          nxt_st.cnt   = 12'h000;
          restart      = 1'b1;
        end
      end
      ST_SETTLE:
      begin
        if (halt_mode)
        begin
          nxt_st.state = ST_IDLE;
        end
        else if (st_ff.cnt <= 12'h001)
        begin
          nxt_st.state       = ST_IDLE;
          nxt_st.settle_pend = 1'b0;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - 12'h001;
        end
      end
      ST_SAMPLE:
      begin
        if (tick)
        begin
          if (st_ff.cnt >= SAMPLE_TICKS - 12'h001)
          begin
            nxt_st.state   = ST_CONV;
            nxt_st.sar     = SAR_FIRST;
            nxt_st.bit_idx = MSB_IDX;
          end
          else
          begin
            nxt_st.cnt = st_ff.cnt + 12'h001;
          end
        end
      end
      ST_CONV:
      begin
        if (tick)
        begin
          // keep the trial bit only while the input stays above the DAC level
          if (!cmp_above)
          begin
            nxt_st.sar[st_ff.bit_idx] = 1'b0;
          end
          // last decision made: the code is handed over from the done state
          if (st_ff.bit_idx == 4'h0)
          begin
            nxt_st.state = ST_DONE;
          end
          else
          begin
            nxt_st.sar[st_ff.bit_idx - 4'h1] = 1'b1;
            nxt_st.bit_idx                   = st_ff.bit_idx - 4'h1;
          end
        end
      end
      ST_DONE:
      begin
        // one spare cycle between conversions lets result and flag update
        nxt_st.state = ST_SAMPLE;
        nxt_st.cnt   = 12'h000;
        restart      = 1'b1;
      end
      default:
      begin
        nxt_st.state = ST_IDLE;
      end
    endcase

    // ------------------------------------------------------------
    // completion: both halves overwritten together
    // ------------------------------------------------------------
    if (done_evt)
    begin
      nxt_st.res = st_ff.sar;
    end

    // ------------------------------------------------------------
    // flag clear by software; a completion in the same cycle wins unless a channel change aborts it in that cycle
    // ------------------------------------------------------------
    if (rd_rh || wr_csr)
    begin
      nxt_st.eoc = 1'b0;
    end
    if (done_evt)
    begin
      nxt_st.eoc = 1'b1;
    end

    // ------------------------------------------------------------
    // control write; the flag bit itself is not writable
    // ------------------------------------------------------------
    if (wr_csr)
    begin
      nxt_st.ch    = pwdata[CH_LSB +: CH_W];
      nxt_st.speed = pwdata[SPEED_BIT];
      nxt_st.on    = pwdata[ON_BIT];
    end

    // ------------------------------------------------------------
    // channel change while running: abort and start over
    // ------------------------------------------------------------
    if (ch_change && pwdata[ON_BIT] && (busy || st_ff.state == ST_DONE))
    begin
      nxt_st.state = ST_SAMPLE;
      nxt_st.cnt   = 12'h000;
      nxt_st.eoc   = 1'b0;
      // an aborted conversion leaves the previous result in place
      nxt_st.res   = st_ff.res;
      restart      = 1'b1;
    end

    // ------------------------------------------------------------
    // off or halted: stop whatever runs
    // ------------------------------------------------------------
    if ((wr_csr && !pwdata[ON_BIT]) || halt_mode)
    begin
      if (st_ff.state != ST_SETTLE)
      begin
        nxt_st.state = ST_IDLE;
      end
    end
    else if (!run && st_ff.state != ST_SETTLE)
    begin
      nxt_st.state = ST_IDLE;
    end

    // ------------------------------------------------------------
    // analog front end, registered
    // ------------------------------------------------------------
    nxt_st.ana.power   = nxt_st.on & ~halt_mode;
    nxt_st.ana.sample  = (nxt_st.state == ST_SAMPLE);
    nxt_st.ana.channel = nxt_st.ch;
    nxt_st.ana.code    = nxt_st.sar;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff.state       <= ST_IDLE;
      st_ff.ch          <= CH_RST;
      st_ff.speed       <= 1'b0;
      st_ff.on          <= 1'b0;
      st_ff.eoc         <= 1'b0;
      st_ff.res         <= RES_RST;
      st_ff.sar         <= RES_RST;
      st_ff.bit_idx     <= 4'h0;
      st_ff.cnt         <= 12'h000;
      st_ff.settle_pend <= 1'b0;
      st_ff.pready      <= 1'b0;
      st_ff.pslverr     <= 1'b0;
      st_ff.prdata      <= 8'h00;
      st_ff.ana         <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // converter clock
  // ------------------------------------------------------------
  // divider runs only while busy, so each conversion starts on a fresh phase
  sac_clk_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (busy),
    .clr     (restart),
    .div2    (st_ff.speed),
    .tick    (tick)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata  = {24'h000000, st_ff.prdata};
  assign pready  = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign ana     = st_ff.ana;

endmodule // sac_adc_ctrl

// ==== hw/sac_pkg.sv ====
// Purpose: shared constants and types of the SAR converter control block
// Assumes: pclk at 250 MHz, APB with 32-bit data, one word per register
// Notes:   printed register offsets are word indices; byte address is four times that
package sac_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  IDX_CSR  = 8'h70;
  localparam logic [7:0]  IDX_RH   = 8'h71;
  localparam logic [7:0]  IDX_RL   = 8'h72;
  localparam logic [11:0] ADDR_CSR = {2'b00, IDX_CSR, 2'b00};
  localparam logic [11:0] ADDR_RH  = {2'b00, IDX_RH, 2'b00};
  localparam logic [11:0] ADDR_RL  = {2'b00, IDX_RL, 2'b00};

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int          EOC_BIT   = 7;
  localparam int          SPEED_BIT = 6;
  localparam int          ON_BIT    = 5;
  localparam int          CH_LSB    = 0;
  localparam int          CH_W      = 4;
  localparam int          RES_W     = 10;
  localparam logic [3:0]  CH_RST    = 4'h0;
  localparam logic [9:0]  RES_RST   = 10'h000;
  localparam logic [9:0]  SAR_FIRST = 10'h200;
  localparam logic [3:0]  MSB_IDX   = 4'h9;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          SETTLE_NS     = 10000;
  localparam int          SETTLE_CYC_I  = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] SETTLE_CYC    = 12'(SETTLE_CYC_I);
  localparam logic [11:0] SAMPLE_TICKS  = 12'h003;
  localparam logic [1:0]  DIV4_LAST     = 2'h3;
  localparam logic [1:0]  DIV2_LAST     = 2'h1;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETTLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b011,
    ST_DONE   = 3'b100
  } sac_state_e;

  typedef struct packed {
    logic            power;
    logic            sample;
    logic [CH_W-1:0] channel;
    logic [RES_W-1:0] code;
  } sac_ana_s;

  typedef struct packed {
    sac_state_e       state;
    logic [CH_W-1:0]  ch;
    logic             speed;
    logic             on;
    logic             eoc;
    logic [RES_W-1:0] res;
    logic [RES_W-1:0] sar;
    logic [3:0]       bit_idx;
    logic [11:0]      cnt;
    logic             settle_pend;
    logic             pready;
    logic             pslverr;
    logic [7:0]       prdata;
    sac_ana_s         ana;
  } sac_state_s;

endpackage

// ==== hw/sac_clk_div.sv ====
// Purpose: converter clock enable, pclk divided by four or by two
// Assumes: clr restarts the phase so a fresh conversion gets a full first period
// Notes:   tick is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
module sac_clk_div
  import sac_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic run,
  input  wire logic clr,
  input  wire logic div2,
  // enable out
  output logic      tick
);

  logic [1:0] cnt_ff;
  logic [1:0] last;

  assign last = div2 ? DIV2_LAST : DIV4_LAST;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 2'h0;
      tick   <= 1'b0;
    end
    else if (!run || clr)
    begin
      cnt_ff <= 2'h0;
      tick   <= 1'b0;
    end
    else
    begin
      tick   <= (cnt_ff == last);
      cnt_ff <= (cnt_ff >= last) ? 2'h0 : cnt_ff + 2'h1;
    end
  end

endmodule // sac_clk_div

// ==== test/sac_adc_monitor.sv ====
// Purpose: port assertions for the converter control block
// Assumes: single pclk domain, async active-low reset
// Notes:   attached by bind from the testbench top
`timescale 1ns/1ps
module sac_adc_monitor
  import sac_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // modes and analog side
  input wire logic        wait_mode,
  input wire logic        halt_mode,
  input wire logic        cmp_above,
  input wire sac_ana_s    ana
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire csr_wr = pready && pwrite && pstrb[0] && paddr == ADDR_CSR;
  wire mapped = paddr == ADDR_CSR || paddr == ADDR_RH || paddr == ADDR_RL;

  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_low_pad: assert property (pready && !pwrite && paddr == ADDR_RL |-> prdata[31:2] == 30'h0)
    else $error("low result upper bits not zero");
  a_resv_zero: assert property (pready && !pwrite && paddr == ADDR_CSR |-> prdata[4] == 1'b0)
    else $error("reserved control bit reads one");
  a_on_start: assert property (csr_wr && pwdata[ON_BIT] && !halt_mode |=> halt_mode || ana.power)
    else $error("converter not powered after on write");
  a_off_stop: assert property (csr_wr && !pwdata[ON_BIT] |=> !ana.power && !ana.sample)
    else $error("converter still running after off write");
  a_halt_off: assert property (halt_mode |=> !ana.power)
    else $error("converter powered in halt");
  a_chan_follow: assert property (csr_wr |=> ana.channel == $past(pwdata[3:0]))
    else $error("channel output does not follow field");
endmodule // sac_adc_monitor

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: apb slave answers within 20 access cycles
// Notes:   comparator input driven directly to force full scale or zero
`timescale 1ns/1ps
module testbench
  import sac_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        wait_mode = 0, halt_mode = 0, cmp_above = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hF;
  sac_ana_s    ana;
  int          mismatches = 0, cmp_count = 0;

  always #2 pclk = ~pclk;

  sac_adc_ctrl u_sac_adc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wait_mode(wait_mode), .halt_mode(halt_mode), .cmp_above(cmp_above), .ana(ana));

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] x, input logic [9:0] g);
    cmp_count++;
    if (g !== x)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // pready, prdata and pslverr are taken at the rising edge that ends the access
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [9:0] x, input string nm);
    logic [7:0] q;
    logic       e;
    apb(1'b0, a, 8'h00, q, e);
    chk(nm, x, {2'b00, q});
  endtask

  task automatic poll;
    logic [7:0] q;
    logic       e;
    int         n;
    n = 0;
    q = 8'h00;
    while (q[7] !== 1'b1 && n < 1500)
    begin
      apb(1'b0, ADDR_CSR, 8'h00, q, e);
      n++;
    end
    if (q[7] !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
  endtask

  // waits, at rising edges, until the sampling output shows v; adds the edges to c
  task automatic wait_smp(input logic v, inout int c);
    int n;
    n = 0;
    while (ana.sample !== v && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    c += n;
    if (ana.sample !== v)
    begin
      mismatches++;
      conclude();
    end
  endtask

  // cycles from one start of sampling to the next
  task automatic gap(output int c);
    int d;
    d = 0;
    wait_smp(1'b0, d);
    wait_smp(1'b1, d);
    c = 0;
    wait_smp(1'b0, c);
    wait_smp(1'b1, c);
  endtask

  task automatic t_reset;
    logic [7:0] q;
    logic       e;
    rd(ADDR_CSR, 10'h000, "control reset");
    rd(ADDR_RH, 10'h000, "high reset");
    rd(ADDR_RL, 10'h000, "low reset");
    apb(1'b0, 12'h1CC, 8'h00, q, e);
    chk("unmapped error", 10'h001, {9'h0, e});
    wr(ADDR_RH, 8'hA5);
    rd(ADDR_RH, 10'h000, "high read only");
    $display("test reset done");
  endtask

  task automatic t_full;
    wait_mode <= 1'b1;
    cmp_above <= 1'b1;
    wr(ADDR_CSR, 8'h65);
    @(posedge pclk);
    chk("channel out", 10'h005, {6'h0, ana.channel});
    poll();
    rd(ADDR_RL, 10'h003, "low full scale");
    rd(ADDR_CSR, 10'h0E5, "eoc kept by low read");
    rd(ADDR_RH, 10'h0FF, "high full scale");
    wait_mode <= 1'b0;
    $display("test full scale done");
  endtask

  task automatic t_zero;
    cmp_above <= 1'b0;
    wr(ADDR_CSR, 8'h2F);
    poll();
    rd(ADDR_RL, 10'h000, "low zero");
    rd(ADDR_RH, 10'h000, "high zero");
    rd(ADDR_CSR, 10'h02F, "eoc cleared by high read");
    $display("test zero done");
  endtask

  task automatic t_chan;
    wr(ADDR_CSR, 8'h22);
    repeat (40) @(posedge pclk);
    cmp_above <= 1'b1;
    wr(ADDR_CSR, 8'h27);
    rd(ADDR_CSR, 10'h027, "eoc after channel change");
    poll();
    rd(ADDR_RL, 10'h003, "low after restart");
    rd(ADDR_RH, 10'h0FF, "high after restart");
    $display("test channel change done");
  endtask

  // the fixed overhead per conversion cancels, leaving the tick count times the period step
  task automatic t_speed;
    int slow;
    int fast;
    slow = 0;
    fast = 0;
    wr(ADDR_CSR, 8'h23);
    gap(slow);
    wr(ADDR_CSR, 8'h63);
    gap(fast);
    chk("speed gap", 10'((SAMPLE_TICKS + RES_W) * (DIV4_LAST - DIV2_LAST)), 10'(slow - fast));
    $display("test speed done");
  endtask

  task automatic t_off;
    wr(ADDR_CSR, 8'h85);
    @(posedge pclk);
    chk("power off", 10'h000, {9'h0, ana.power});
    repeat (100) @(posedge pclk);
    rd(ADDR_CSR, 10'h005, "no eoc while off");
    $display("test off done");
  endtask

  task automatic t_halt;
    wr(ADDR_CSR, 8'h61);
    halt_mode <= 1'b1;
    repeat (100) @(posedge pclk);
    chk("power in halt", 10'h000, {9'h0, ana.power});
    rd(ADDR_CSR, 10'h061, "no eoc in halt");
    halt_mode <= 1'b0;
    poll();
    rd(ADDR_RH, 10'h0FF, "result after wakeup");
    $display("test halt done");
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_full();
    t_zero();
    t_chan();
    t_speed();
    t_off();
    t_halt();
    conclude();
  end
endmodule // testbench

bind sac_adc_ctrl sac_adc_monitor u_sac_adc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode), .halt_mode(halt_mode),
  .cmp_above(cmp_above), .ana(ana));
